// [cct_consts.svh]
// cct_consts.svh: register indices, field positions, reset values and sizes of the timer
// assumes byte address = 4 x register index on an avalon-mm bus with 32-bit data
`ifndef CCT_CONSTS_SVH
`define CCT_CONSTS_SVH

// ******************************************************************
// register indices
// ******************************************************************
`define CCT_IDX_STATUS_CTRL 8'h20
`define CCT_IDX_CNT_HI      8'h21
`define CCT_IDX_CNT_LO      8'h22
`define CCT_IDX_MOD_HI      8'h23
`define CCT_IDX_MOD_LO      8'h24
`define CCT_IDX_CH0_CTRL    8'h25
`define CCT_IDX_CH0_VAL_HI  8'h26
`define CCT_IDX_CH0_VAL_LO  8'h27
`define CCT_IDX_CH1_CTRL    8'h28
`define CCT_IDX_CH1_VAL_HI  8'h29
`define CCT_IDX_CH1_VAL_LO  8'h2A

// ******************************************************************
// fields, reset values, sizes
// ******************************************************************
`define CCT_SC_FLAG_BIT     7
`define CCT_SC_IE_BIT       6
`define CCT_SC_HALT_BIT     5
`define CCT_SC_CLEAR_BIT    4
`define CCT_CH_FLAG_BIT     7
`define CCT_CH1_NOBIT_MASK  7'h5F
`define CCT_CH0_MASK        7'h7F
`define CCT_SC_HALT_RST     1'h1
`define CCT_MOD_RST         16'hFFFF
`define CCT_PS_RESERVED     3'h7
`define CCT_PS_SLOWEST      3'h6
`define CCT_PRE_W           6

`endif

// [cct_pkg.sv]
// cct_pkg: types shared by the timer modules
// assumes nothing beyond the constants header
package cct_pkg;

    // channel control byte, bit 7 down to bit 0
    typedef struct packed {
        logic flag;
        logic irq_en;
        logic mode_b;
        logic mode_a;
        logic edge_b;
        logic edge_a;
        logic ovf_toggle;
        logic max_duty;
    } cct_chctl_t;

    // compare action held in edge_b:edge_a
    typedef enum logic [1:0] {
        CCT_ACT_NONE   = 2'h0,
        CCT_ACT_TOGGLE = 2'h1,
        CCT_ACT_CLEAR  = 2'h2,
        CCT_ACT_SET    = 2'h3
    } cct_action_t;

endpackage : cct_pkg

// [cct_prescaler.sv]
// cct_prescaler: divides the bus clock into seven selectable tick rates
// assumes clear and select come from the register bank on the same clock
`timescale 1ns/1ns
`include "cct_consts.svh"
module cct_prescaler
    import cct_pkg::*;
#(
    parameter int PRE_W = `CCT_PRE_W
) (
    input  logic       clk,
    input  logic       reset,
    input  logic       clear,
    input  logic [2:0] select,
    output logic       tick
);

    logic [PRE_W-1:0] div_reg;

    // low bits that must all be ones for a tick; the spare code aliases the slowest rate
    function automatic logic [PRE_W-1:0] tap_mask(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel == `CCT_PS_RESERVED) ? `CCT_PS_SLOWEST : sel;
        return PRE_W'((32'h1 << s) - 32'h1);
    endfunction : tap_mask

    assign tick = &(div_reg | ~tap_mask(select));

    always_ff @(posedge clk) begin
        if (reset || clear) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + PRE_W'(1);
        end
    end

endmodule : cct_prescaler

// [cct_timer.sv]
// cct_timer: two-channel 16-bit capture/compare timer with an avalon-mm register slave
// assumes one 25 MHz clock, pins synchronous to it, a master that honours waitrequest
`timescale 1ns/1ns
`include "cct_consts.svh"
module cct_timer
    import cct_pkg::*;
#(
    parameter int PRE_W = `CCT_PRE_W
) (
    input  logic        clk,
    input  logic        reset,
    input  logic [9:0]  avs_address,
    input  logic        avs_read,
    input  logic        avs_write,
    input  logic [31:0] avs_writedata,
    input  logic [3:0]  avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic        avs_waitrequest,
    input  logic [1:0]  ch_pin_in,
    output logic [1:0]  ch_pin_out,
    output logic [1:0]  ch_pin_oe,
    output logic        irq_overflow,
    output logic [1:0]  irq_channel
);

    // ******************************************************************
    // avalon-mm slave: one wait state, then the access completes
    // ******************************************************************
    localparam logic [7:0] CTL_IDX [2] = '{`CCT_IDX_CH0_CTRL, `CCT_IDX_CH1_CTRL};
    localparam logic [7:0] VH_IDX  [2] = '{`CCT_IDX_CH0_VAL_HI, `CCT_IDX_CH1_VAL_HI};
    localparam logic [7:0] VL_IDX  [2] = '{`CCT_IDX_CH0_VAL_LO, `CCT_IDX_CH1_VAL_LO};
    localparam logic [6:0] CTL_MSK [2] = '{`CCT_CH0_MASK, `CCT_CH1_NOBIT_MASK};

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        return idx == want;
    endfunction : hit

    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [7:0]  rd_mux;

    wire       bus_req = avs_read | avs_write;
    wire [7:0] reg_idx = avs_address[9:2];
    wire [7:0] wd      = avs_writedata[7:0];
    wire       rd_go   = avs_read & ~ack_reg;
    wire       wr_go   = avs_write & ack_reg & avs_byteenable[0];
    wire       wr_sc   = wr_go & hit(reg_idx, `CCT_IDX_STATUS_CTRL);
    wire       wr_modh = wr_go & hit(reg_idx, `CCT_IDX_MOD_HI);
    wire       wr_modl = wr_go & hit(reg_idx, `CCT_IDX_MOD_LO);

    assign avs_waitrequest = bus_req & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_reg   <= 1'h0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (rd_go) begin
                rdata_reg <= {24'h000000, rd_mux};
            end
        end
    end

    // ******************************************************************
    // status/control and modulo registers
    // ******************************************************************
    logic        ovf_flag_reg;
    logic        ovf_ie_reg;
    logic        halt_reg;
    logic [2:0]  psel_reg;
    logic        ovf_arm_reg;
    logic [15:0] modulo_reg;
    logic [15:0] count_reg;
    logic        step_reg;
    logic        tick;

    wire clr_go  = wr_sc & wd[`CCT_SC_CLEAR_BIT];
    wire adv     = tick & ~halt_reg & ~clr_go;
    wire at_mod  = count_reg == modulo_reg;
    wire ovf_evt = adv & at_mod;
    wire ovf_arm = rd_go & hit(reg_idx, `CCT_IDX_STATUS_CTRL) & ovf_flag_reg;
    wire ovf_clr = wr_sc & ovf_arm_reg & ~wd[`CCT_SC_FLAG_BIT];

    always_ff @(posedge clk) begin
        if (reset) begin
            ovf_flag_reg <= 1'h0;
            ovf_ie_reg   <= 1'h0;
            halt_reg     <= `CCT_SC_HALT_RST;
            psel_reg     <= 3'h0;
            ovf_arm_reg  <= 1'h0;
            modulo_reg   <= `CCT_MOD_RST;
        end else begin
            // a new overflow wins over a clear in the same cycle
            ovf_flag_reg <= ovf_evt | (ovf_flag_reg & ~ovf_clr);
            ovf_arm_reg  <= ovf_arm | (ovf_arm_reg & ~wr_sc);
            if (wr_sc) begin
                ovf_ie_reg <= wd[`CCT_SC_IE_BIT];
                halt_reg   <= wd[`CCT_SC_HALT_BIT];
                psel_reg   <= wd[2:0];
            end
            if (wr_modh) begin
                modulo_reg[15:8] <= wd;
            end
            if (wr_modl) begin
                modulo_reg[7:0] <= wd;
            end
        end
    end

    // ******************************************************************
    // prescaler and counter
    // ******************************************************************
    cct_prescaler #(
        .PRE_W (PRE_W)
    ) u_prescaler (
        .clk    (clk),
        .reset  (reset),
        .clear  (clr_go),
        .select (psel_reg),
        .tick   (tick)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            count_reg <= 16'h0000;
            step_reg  <= 1'h0;
        end else begin
            step_reg <= adv | clr_go;
            if (clr_go) begin
                count_reg <= 16'h0000;
            end else if (adv) begin
                count_reg <= at_mod ? 16'h0000 : count_reg + 16'h0001;
            end
        end
    end

    // ******************************************************************
    // channels
    // ******************************************************************
    cct_chctl_t  ctl_reg [2];
    logic [15:0] val_reg [2];
    logic [15:0] cmp_val [2];
    logic [1:0]  pin_reg;
    logic [1:0]  prev_reg;
    logic [1:0]  arm_reg;
    logic        act_sel_reg;
    logic        pend_sel_reg;
    logic [1:0]  cap_mode;
    logic [1:0]  cmp_mode;
    logic [1:0]  cap_hit;
    logic [1:0]  cmp_hit;
    logic [1:0]  ch_evt;
    logic [1:0]  wr_ctl;
    logic [1:0]  wr_vh;
    logic [1:0]  wr_vl;
    logic [1:0]  arm_set;
    logic [1:0]  flag_clr;
    logic [1:0]  drive_en;

    wire linked = ctl_reg[0].mode_b;

    // in linked mode channel 0 compares against whichever set is active
    assign cmp_val[0] = (linked & act_sel_reg) ? val_reg[1] : val_reg[0];
    assign cmp_val[1] = val_reg[1];
    assign cap_mode[0] = ~ctl_reg[0].mode_b & ~ctl_reg[0].mode_a;
    assign cmp_mode[0] = ctl_reg[0].mode_b | ctl_reg[0].mode_a;
    assign cap_mode[1] = ~linked & ~ctl_reg[1].mode_a;
    assign cmp_mode[1] = ~linked & ctl_reg[1].mode_a;

    // next pin level from overflow toggle and compare action
    function automatic logic pin_next(input logic cur, input cct_chctl_t c,
                                      input logic ovf, input logic cmp);
        logic nxt;
        nxt = cur;
        if (ovf && c.ovf_toggle) begin
            nxt = ~cur;
        end else if (cmp && !(c.max_duty && c.ovf_toggle)) begin
            unique case (cct_action_t'({c.edge_b, c.edge_a}))
                CCT_ACT_NONE:   nxt = cur;
                CCT_ACT_TOGGLE: nxt = ~cur;
                CCT_ACT_CLEAR:  nxt = 1'h0;
                CCT_ACT_SET:    nxt = 1'h1;
            endcase
        end
        return nxt;
    endfunction : pin_next

    for (genvar c = 0; c < 2; c++) begin : g_ch
        wire rise = ch_pin_in[c] & ~prev_reg[c];
        wire fall = ~ch_pin_in[c] & prev_reg[c];
        // edge_a picks rising, edge_b falling, both picks either edge
        assign cap_hit[c]  = cap_mode[c]
                           & ((ctl_reg[c].edge_a & rise) | (ctl_reg[c].edge_b & fall));
        // outside linked mode the live value register is compared, so a write acts at once
        assign cmp_hit[c]  = cmp_mode[c] & step_reg & (count_reg == cmp_val[c]);
        assign ch_evt[c]   = cap_hit[c] | cmp_hit[c];
        assign drive_en[c] = cmp_mode[c] & (ctl_reg[c].edge_a | ctl_reg[c].edge_b);
        assign wr_ctl[c]   = wr_go & hit(reg_idx, CTL_IDX[c]);
        assign wr_vh[c]    = wr_go & hit(reg_idx, VH_IDX[c]);
        assign wr_vl[c]    = wr_go & hit(reg_idx, VL_IDX[c]);
        assign arm_set[c]  = rd_go & hit(reg_idx, CTL_IDX[c]) & ctl_reg[c].flag;
        assign flag_clr[c] = wr_ctl[c] & arm_reg[c] & ~wd[`CCT_CH_FLAG_BIT];
        assign irq_channel[c] = ctl_reg[c].flag & ctl_reg[c].irq_en
                              & ~(linked & (c == 1));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int c = 0; c < 2; c++) begin
                ctl_reg[c] <= '0;
                val_reg[c] <= 16'h0000;
            end
            pin_reg  <= 2'h0;
            prev_reg <= 2'h0;
            arm_reg  <= 2'h0;
        end else begin
            prev_reg <= ch_pin_in;
            for (int c = 0; c < 2; c++) begin
                ctl_reg[c].flag <= ch_evt[c] | (ctl_reg[c].flag & ~flag_clr[c]);
                arm_reg[c] <= arm_set[c] | (arm_reg[c] & ~wr_ctl[c]);
                if (wr_ctl[c]) begin
                    ctl_reg[c][6:0] <= wd[6:0] & CTL_MSK[c];
                end
                // a capture takes priority over a software write in the same cycle
                if (cap_hit[c]) begin
                    val_reg[c] <= count_reg;
                end else begin
                    if (wr_vh[c]) begin
                        val_reg[c][15:8] <= wd;
                    end
                    if (wr_vl[c]) begin
                        val_reg[c][7:0] <= wd;
                    end
                end
                pin_reg[c] <= pin_next(pin_reg[c], ctl_reg[c],
                                       ovf_evt & cmp_mode[c], cmp_hit[c]);
            end
        end
    end

    // ******************************************************************
    // buffered compare: which value set is active
    // ******************************************************************
    always_ff @(posedge clk) begin
        if (reset || !linked) begin
            act_sel_reg  <= 1'h0;
            pend_sel_reg <= 1'h0;
        end else begin
            // the set written last takes over at the next overflow
            if (wr_vh[1] || wr_vl[1]) begin
                pend_sel_reg <= 1'h1;
            end else if (wr_vh[0] || wr_vl[0]) begin
                pend_sel_reg <= 1'h0;
            end
            if (ovf_evt) begin
                act_sel_reg <= pend_sel_reg;
            end
        end
    end

    // ******************************************************************
    // outputs and read mux
    // ******************************************************************
    assign ch_pin_out   = pin_reg;
    assign ch_pin_oe    = drive_en;
    assign irq_overflow = ovf_flag_reg & ovf_ie_reg;

    wire [7:0] sc_rd = {ovf_flag_reg, ovf_ie_reg, halt_reg, 2'h0, psel_reg};

    // reads select stored state only; nothing in the counter path sees them
    assign rd_mux = hit(reg_idx, `CCT_IDX_STATUS_CTRL) ? sc_rd :
                    hit(reg_idx, `CCT_IDX_CNT_HI)      ? count_reg[15:8] :
                    hit(reg_idx, `CCT_IDX_CNT_LO)      ? count_reg[7:0] :
                    hit(reg_idx, `CCT_IDX_MOD_HI)      ? modulo_reg[15:8] :
                    hit(reg_idx, `CCT_IDX_MOD_LO)      ? modulo_reg[7:0] :
                    hit(reg_idx, `CCT_IDX_CH0_CTRL)    ? ctl_reg[0] :
                    hit(reg_idx, `CCT_IDX_CH0_VAL_HI)  ? val_reg[0][15:8] :
                    hit(reg_idx, `CCT_IDX_CH0_VAL_LO)  ? val_reg[0][7:0] :
                    hit(reg_idx, `CCT_IDX_CH1_CTRL)    ? ctl_reg[1] :
                    hit(reg_idx, `CCT_IDX_CH1_VAL_HI)  ? val_reg[1][15:8] :
                    hit(reg_idx, `CCT_IDX_CH1_VAL_LO)  ? val_reg[1][7:0] :
                    8'h00;

    // ******************************************************************
    // assertions
    // ******************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_req_start;
        bus_req && !ack_reg;
    endsequence

    sequence s_req_done;
        !avs_waitrequest ##1 !ack_reg;
    endsequence

    sequence s_ovf_armed;
        ovf_arm_reg && !ovf_evt;
    endsequence

    sequence s_ovf_zero_write;
        wr_sc && !wd[`CCT_SC_FLAG_BIT];
    endsequence

    a_bus_one_wait: assert property (
        s_req_start |-> avs_waitrequest ##1 s_req_done)
        else $error("bus access did not finish after one wait state");

    a_halt_holds_count: assert property (
        halt_reg && !clr_go |=> $stable(count_reg))
        else $error("counter moved while halted");

    a_wrap_to_zero: assert property (
        ovf_evt |=> count_reg == 16'h0000 && ovf_flag_reg)
        else $error("overflow did not wrap and flag");

    a_count_step_one: assert property (
        adv && !at_mod |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter did not advance by one");

    a_clear_zeroes: assert property (
        clr_go |=> count_reg == 16'h0000 ##1 (count_reg <= 16'h0001))
        else $error("clear did not reset the counter");

    a_read_no_disturb: assert property (
        rd_go && !adv && !clr_go |=> $stable(count_reg))
        else $error("counter read changed the count");

    a_capture_value: assert property (
        cap_hit[0] |=> val_reg[0] == $past(count_reg) && ctl_reg[0].flag)
        else $error("capture did not latch the counter");

    a_compare_set: assert property (
        cmp_hit[0] && !ovf_evt && !ctl_reg[0].max_duty
        && {ctl_reg[0].edge_b, ctl_reg[0].edge_a} == 2'h3 |=> pin_reg[0])
        else $error("compare did not set the pin");

    a_ovf_flag_clear: assert property (
        s_ovf_armed ##0 s_ovf_zero_write |=> !ovf_flag_reg && !irq_overflow)
        else $error("overflow flag not cleared by read then write zero");

    a_ovf_irq: assert property (
        ovf_evt && ovf_ie_reg && !wr_sc |=> irq_overflow)
        else $error("overflow request missing");

    a_ch_irq: assert property (
        ch_evt[1] && ctl_reg[1].irq_en && !wr_ctl[1] && !wr_ctl[0] |=> irq_channel[1])
        else $error("channel request missing");

    a_ch1_released: assert property (
        linked |-> !ch_pin_oe[1] && !ch_evt[1] && !irq_channel[1])
        else $error("second channel active while linked");

    a_bit5_zero: assert property (
        rd_go && hit(reg_idx, `CCT_IDX_CH1_CTRL) |=> !rdata_reg[5])
        else $error("channel 1 bit 5 read as one");

    a_buffer_swap: assert property (
        linked && ovf_evt && !wr_ctl[0] |=> act_sel_reg == $past(pend_sel_reg))
        else $error("active set not swapped at overflow");

endmodule : cct_timer

// [cct_pin_model.sv]
// cct_pin_model: outside drivers on the two timer channel pins
// assumes the bench sets ext_level by non-blocking assignment after a rising edge
`timescale 1ns/1ns
module cct_pin_model
    import cct_pkg::*;
(
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    input  wire logic [1:0] ext_level,
    output logic      [1:0] pin_in
);
    // a pin shows the timer drive while enabled, else the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : cct_pin_model

// [cct_timer_bench.sv]
// cct_timer_bench: self-checking bench for the capture/compare timer
// assumes the design's avalon-mm slave, one 40 ns clock and the pin model
`timescale 1ns/1ns
`include "cct_consts.svh"
module cct_timer_bench
    import cct_pkg::*;
;
    logic        clk;
    logic        reset;
    logic [9:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  ch_pin_in;
    logic [1:0]  ch_pin_out;
    logic [1:0]  ch_pin_oe;
    logic        irq_overflow;
    logic [1:0]  irq_channel;
    logic [1:0]  ext_level;
    logic [7:0]  rd;
    logic [15:0] cnt;
    logic        p;
    int          n_errors;
    int          compares;

    cct_timer i_cct_timer (.clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
        .ch_pin_oe(ch_pin_oe), .irq_overflow(irq_overflow), .irq_channel(irq_channel));
    cct_pin_model i_cct_pin_model (.pin_out(ch_pin_out), .pin_oe(ch_pin_oe),
        .ext_level(ext_level), .pin_in(ch_pin_in));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        avs_address   <= {idx, 2'h0};
        avs_writedata <= {24'h0, d};
        avs_write     <= wr_en;
        avs_read      <= ~wr_en;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
        chk(16'(n < 50), 16'h1, "bus answer");
    endtask : bus

    task wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr

    task rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        bus(1'b0, idx, 8'h00);
        chk({8'h00, rd}, {8'h00, exp}, what);
    endtask : rdchk

    task run(input int c);
        repeat (c) @(posedge clk);
    endtask : run

    task read_count;
        bus(1'b0, `CCT_IDX_CNT_HI, 8'h00);
        cnt[15:8] = rd;
        bus(1'b0, `CCT_IDX_CNT_LO, 8'h00);
        cnt[7:0] = rd;
    endtask : read_count

    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        rdchk(`CCT_IDX_STATUS_CTRL, 8'h20, "status reset");
        rdchk(`CCT_IDX_CNT_HI, 8'h00, "count high reset");
        rdchk(`CCT_IDX_CNT_LO, 8'h00, "count low reset");
        rdchk(`CCT_IDX_MOD_HI, 8'hFF, "modulo high reset");
        rdchk(`CCT_IDX_MOD_LO, 8'hFF, "modulo low reset");
        rdchk(`CCT_IDX_CH0_CTRL, 8'h00, "ch0 control reset");
        rdchk(`CCT_IDX_CH1_CTRL, 8'h00, "ch1 control reset");
        chk({12'h0, ch_pin_oe, irq_channel}, 16'h0, "pins idle");
        wr(`CCT_IDX_STATUS_CTRL, 8'hA0);
        rdchk(`CCT_IDX_STATUS_CTRL, 8'h20, "flag write one");
        wr(`CCT_IDX_CH1_CTRL, 8'h60);
        rdchk(`CCT_IDX_CH1_CTRL, 8'h40, "ch1 bit five");
        wr(`CCT_IDX_CH1_CTRL, 8'h00);
        wr(`CCT_IDX_CNT_LO, 8'h55);
        rdchk(`CCT_IDX_CNT_LO, 8'h00, "count read only");
        rdchk(8'h30, 8'h00, "unmapped read");
        avs_byteenable <= 4'h0;
        wr(`CCT_IDX_MOD_LO, 8'h00);
        avs_byteenable <= 4'hF;
        rdchk(`CCT_IDX_MOD_LO, 8'hFF, "masked write");
    endtask : t_reset

    task t_prescale;
        int exp;
        for (int s = 0; s < 8; s++) begin
            wr(`CCT_IDX_STATUS_CTRL, 8'h30 | 8'(s));
            rdchk(`CCT_IDX_CNT_LO, 8'h00, "count after clear");
            wr(`CCT_IDX_STATUS_CTRL, 8'(s));
            run(640);
            wr(`CCT_IDX_STATUS_CTRL, 8'h20 | 8'(s));
            read_count;
            rdchk(`CCT_IDX_CNT_LO, cnt[7:0], "count steady");
            exp = 640 >> ((s > 6) ? 6 : s);
            chk(16'(int'(cnt) >= exp - 2 && int'(cnt) <= exp + 8), 16'h1, "tick rate");
        end
    endtask : t_prescale

    task t_capture;
        logic [7:0] c;
        read_count;
        for (int i = 1; i < 4; i++) begin
            c = {4'h4, 2'(i), 2'h0};
            wr(`CCT_IDX_CH0_VAL_HI, 8'h00);
            wr(`CCT_IDX_CH0_VAL_LO, 8'h00);
            wr(`CCT_IDX_CH0_CTRL, c);
            ext_level[0] <= 1'b1;
            run(2);
            rdchk(`CCT_IDX_CH0_CTRL, c | {c[2], 7'h0}, "rising capture");
            chk({15'h0, irq_channel[0]}, {15'h0, c[2]}, "capture request");
            rdchk(`CCT_IDX_CH0_VAL_LO, c[2] ? cnt[7:0] : 8'h00, "rising value");
            wr(`CCT_IDX_CH0_CTRL, c);
            ext_level[0] <= 1'b0;
            run(2);
            rdchk(`CCT_IDX_CH0_CTRL, c | {c[3], 7'h0}, "falling capture");
            rdchk(`CCT_IDX_CH0_VAL_HI, cnt[15:8], "captured high");
            wr(`CCT_IDX_CH0_CTRL, 8'h00);
        end
        wr(`CCT_IDX_CH1_CTRL, 8'h04);
        ext_level[1] <= 1'b1;
        run(2);
        rdchk(`CCT_IDX_CH1_CTRL, 8'h84, "ch1 capture");
        chk({14'h0, irq_channel}, 16'h0, "masked request");
        wr(`CCT_IDX_CH1_CTRL, 8'h00);
        rdchk(`CCT_IDX_CH1_VAL_LO, cnt[7:0], "ch1 value");
        wr(`CCT_IDX_CH1_CTRL, 8'h48);
        ext_level[1] <= 1'b0;
        run(2);
        chk({14'h0, irq_channel}, 16'h2, "ch1 request");
        rdchk(`CCT_IDX_CH1_CTRL, 8'hC8, "ch1 falling flag");
        wr(`CCT_IDX_CH1_CTRL, 8'h00);
    endtask : t_capture

    task t_overflow;
        wr(`CCT_IDX_MOD_HI, 8'h00);
        wr(`CCT_IDX_MOD_LO, 8'h05);
        wr(`CCT_IDX_STATUS_CTRL, 8'h50);
        run(20);
        wr(`CCT_IDX_STATUS_CTRL, 8'h60);
        rdchk(`CCT_IDX_STATUS_CTRL, 8'hE0, "overflow flag");
        chk({15'h0, irq_overflow}, 16'h1, "overflow request");
        read_count;
        chk(16'(cnt <= 16'h0005), 16'h1, "count wraps");
        wr(`CCT_IDX_STATUS_CTRL, 8'h60);
        rdchk(`CCT_IDX_STATUS_CTRL, 8'h60, "flag cleared");
        chk({15'h0, irq_overflow}, 16'h0, "request dropped");
        wr(`CCT_IDX_STATUS_CTRL, 8'h20);
        wr(`CCT_IDX_MOD_LO, 8'hFF);
    endtask : t_overflow

    // one pass of about 20 counts at one count per clock, starting from zero only when clr is set
    task seg(input logic clr);
        if (clr) wr(`CCT_IDX_STATUS_CTRL, 8'h30);
        wr(`CCT_IDX_STATUS_CTRL, 8'h00);
        run(16);
        wr(`CCT_IDX_STATUS_CTRL, 8'h20);
        run(3);
    endtask : seg

    task t_compare;
        logic [7:0] code [4];
        code = '{8'h1C, 8'h18, 8'h14, 8'h14};
        wr(`CCT_IDX_CH0_VAL_LO, 8'h08);
        for (int i = 0; i < 4; i++) begin
            wr(`CCT_IDX_CH0_CTRL, code[i]);
            seg(1'b1);
            chk({14'h0, ch_pin_oe}, 16'h1, "compare drive");
            chk({15'h0, ch_pin_out[0]}, 16'(i % 2 == 0), "compare action");
            rdchk(`CCT_IDX_CH0_CTRL, code[i] | 8'h80, "compare flag");
        end
        wr(`CCT_IDX_CH0_CTRL, 8'h1C);
        wr(`CCT_IDX_CH0_VAL_LO, 8'h40);
        seg(1'b1);
        wr(`CCT_IDX_CH0_VAL_LO, 8'h10);
        seg(1'b0);
        chk({15'h0, ch_pin_out[0]}, 16'h0, "passed value missed");
        wr(`CCT_IDX_CH0_VAL_LO, 8'h30);
        seg(1'b0);
        chk({15'h0, ch_pin_out[0]}, 16'h1, "new value used");
        rdchk(`CCT_IDX_CH0_CTRL, 8'h9C, "new value flag");
        wr(`CCT_IDX_CH0_CTRL, 8'h18);
        wr(`CCT_IDX_CH0_VAL_LO, 8'h04);
        seg(1'b1);
        chk({15'h0, ch_pin_out[0]}, 16'h0, "lowered value used");
        rdchk(`CCT_IDX_CH0_CTRL, 8'h98, "lowered value flag");
    endtask : t_compare

    task t_linked;
        wr(`CCT_IDX_CH1_CTRL, 8'h1C);
        chk({15'h0, ch_pin_oe[1]}, 16'h1, "ch1 drives");
        wr(`CCT_IDX_CH0_VAL_HI, 8'h01);
        wr(`CCT_IDX_CH0_VAL_LO, 8'h00);
        wr(`CCT_IDX_CH0_CTRL, 8'h64);
        chk({14'h0, ch_pin_oe}, 16'h1, "second pin released");
        p = ch_pin_out[0];
        seg(1'b1);
        wr(`CCT_IDX_CH1_VAL_HI, 8'h00);
        wr(`CCT_IDX_CH1_VAL_LO, 8'h20);
        wr(`CCT_IDX_STATUS_CTRL, 8'h00);
        run(32);
        wr(`CCT_IDX_STATUS_CTRL, 8'h20);
        chk({15'h0, ch_pin_out[0]}, {15'h0, p}, "set one waits");
        wr(`CCT_IDX_STATUS_CTRL, 8'h00);
        run(256);
        wr(`CCT_IDX_STATUS_CTRL, 8'h20);
        chk({15'h0, ch_pin_out[0]}, {15'h0, ~p}, "set one governs");
        rdchk(`CCT_IDX_CH0_CTRL, 8'hE4, "linked flag");
        chk({14'h0, irq_channel}, 16'h1, "linked request");
    endtask : t_linked

    // ****************************************
    // run control
    // ****************************************
    task finish_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        $display("wrong value at %0t ns: watchdog expired", $time);
        finish_test;
    end

    initial begin
        reset = 1'b1;
        avs_address = 10'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        ext_level = 2'h0;
        n_errors = 0;
        compares = 0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset;
        t_prescale;
        t_capture;
        t_overflow;
        t_compare;
        t_linked;
        finish_test;
    end
endmodule : cct_timer_bench
